// ---- verilog/cthw_pkg.sv ----
// package: register map, field layout, decode tables and timing of the timer/option block
package cthw_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned TICK_NS = 10000;
   localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TICKS_PER_MS = 1000000 / TICK_NS;
   localparam int unsigned CNT_W = 24;

   localparam logic [6:0] ADR_WAKE_CTRL = 7'h06;
   localparam logic [6:0] ADR_TIMER_CTRL = 7'h0c;
   localparam logic [6:0] ADR_HW_OPT = 7'h0e;
   localparam logic [6:0] ADR_HW_LOCK = 7'h0f;
   localparam logic [6:0] ADR_PIN_CFG = 7'h17;

   localparam logic [4:0] FRAME_LEN = 5'h10;
   localparam logic [4:0] ADDR_DONE = 5'h08;
   localparam logic [4:0] FRAME_OVER = 5'h11;
   localparam int unsigned WR_BIT = 7;

   localparam int unsigned TMR_ON_LSB = 4;
   localparam int unsigned UVH_BIT = 7;
   localparam int unsigned OTX_BIT = 5;
   localparam int unsigned RDS_BIT = 4;
   localparam int unsigned LK0_BIT = 3;
   localparam int unsigned LK1_BIT = 0;
   localparam int unsigned WAKE_EN_BIT = 6;

   localparam logic [6:0] TMR_CTRL_RST = 7'h00;
   localparam logic [2:0] OPT_RST = 3'h0;
   localparam logic [2:0] PIN_CFG_RST = 3'h0;

   localparam logic [2:0] ON_OFF_LO = 3'h0;
   localparam logic [2:0] ON_OFF_HI = 3'h6;
   localparam logic [3:0] PER_LAST = 4'hc;
   localparam logic [2:0] PIN_CYCLIC_SENSE = 3'h3;

   localparam int unsigned TSD_WAIT_MS = 1000;
   localparam int unsigned TSD_EXT_FACTOR = 64;
   localparam logic [4:0] TSD_STREAK_LIMIT = 5'h10;
   localparam logic [4:0] TSD_STREAK_SAT = 5'h11;
   localparam logic [CNT_W-1:0] TSD_SHORT_TICKS = CNT_W'(TSD_WAIT_MS * TICKS_PER_MS);
   localparam logic [CNT_W-1:0] TSD_LONG_TICKS =
      CNT_W'(TSD_WAIT_MS * TICKS_PER_MS * TSD_EXT_FACTOR);

   typedef enum logic [1:0] {
      TMR_IDLE = 2'b00,
      TMR_ON = 2'b01,
      TMR_OFF = 2'b10
   } cthw_tmr_state_t;

   // on-time in microseconds, converted to ticks
   function automatic logic [CNT_W-1:0] on_ticks(input logic [2:0] code);
      int unsigned us;
      us = 0;
      case (code)
         3'h1: us = 100;
         3'h2: us = 300;
         3'h3: us = 1000;
         3'h4: us = 10000;
         3'h5: us = 20000;
         default: us = 0;
      endcase
      return CNT_W'(us * TICKS_PER_MS / 1000);
   endfunction : on_ticks

   // period in milliseconds, converted to ticks
   function automatic logic [CNT_W-1:0] period_ticks(input logic [3:0] code);
      int unsigned ms;
      ms = 0;
      case (code)
         4'h0: ms = 10;
         4'h1: ms = 20;
         4'h2: ms = 50;
         4'h3: ms = 100;
         4'h4: ms = 200;
         4'h5: ms = 500;
         4'h6: ms = 1000;
         4'h7: ms = 2000;
         4'h8: ms = 5000;
         4'h9: ms = 10000;
         4'ha: ms = 20000;
         4'hb: ms = 50000;
         4'hc: ms = 100000;
         default: ms = 0;
      endcase
      return CNT_W'(ms * TICKS_PER_MS);
   endfunction : period_ticks
endpackage : cthw_pkg

// ---- verilog/cthw_cycle_timer.sv ----
// cyclic timer: on-time/period sequencer driving the high-side request and period pulses
module cthw_cycle_timer
   import cthw_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic tick,
   input wire logic load,
   input wire logic [2:0] on_code,
   input wire logic [3:0] per_code,
   output logic hs,
   output logic period_start
);
   cthw_tmr_state_t st_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_inc;
   logic run;
   logic hs_d;

   // reserved on-time and period codes leave the timer stopped
   assign run = (on_code != ON_OFF_LO) && (on_code < ON_OFF_HI)
      && (per_code <= PER_LAST);
   assign cnt_inc = cnt_q + CNT_W'(1);

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= TMR_IDLE;
         cnt_q <= '0;
         period_start <= 1'b0;
      end else if (ce) begin
         period_start <= 1'b0;
         if (load || !run) begin
            // a new setting restarts the sequence at once
            cnt_q <= '0;
            if (run) begin
               st_q <= TMR_ON;
               period_start <= 1'b1;
            end else begin
               st_q <= TMR_IDLE;
            end
         end else if (tick && st_q != TMR_IDLE) begin
            if (cnt_inc >= period_ticks(per_code)) begin
               cnt_q <= '0;
               st_q <= TMR_ON;
               period_start <= 1'b1;
            end else begin
               cnt_q <= cnt_inc;
               if (cnt_inc >= on_ticks(on_code)) begin
                  st_q <= TMR_OFF;
               end
            end
         end
      end
   end

   always_comb begin
      unique case (st_q)
         TMR_ON: hs_d = 1'b1;
         TMR_OFF: hs_d = 1'b0;
         TMR_IDLE: hs_d = (on_code == ON_OFF_HI);
         default: hs_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hs <= 1'b0;
      end else if (ce) begin
         hs <= hs_d;
      end
   end
endmodule : cthw_cycle_timer

// ---- verilog/cthw_overtemp_wait.sv ----
// overtemperature release wait with consecutive-event streak and optional extension
module cthw_overtemp_wait
   import cthw_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic tick,
   input wire logic trip,
   input wire logic extend,
   input wire logic streak_clr,
   output logic waiting
);
   logic [4:0] streak_q;
   logic [CNT_W-1:0] wait_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         streak_q <= 5'h00;
         wait_q <= '0;
      end else if (ce) begin
         if (trip) begin
            if (streak_q != TSD_STREAK_SAT) begin
               streak_q <= streak_q + 5'h01;
            end
            // this event is number streak_q+1, so >16 means old count >=16
            if (extend && streak_q >= TSD_STREAK_LIMIT) begin
               wait_q <= TSD_LONG_TICKS;
            end else begin
               wait_q <= TSD_SHORT_TICKS;
            end
         end else begin
            if (streak_clr) begin
               streak_q <= 5'h00;
            end
            if (tick && wait_q != '0) begin
               wait_q <= wait_q - CNT_W'(1);
            end
         end
      end
   end

   assign waiting = (wait_q != '0);
endmodule : cthw_overtemp_wait

// ---- verilog/cthw_ctrl_regs.sv ----
// top: serial register port, cyclic timer control and hardware option registers
module cthw_ctrl_regs
   import cthw_pkg::*;
#(
   parameter int unsigned TICK_LEN = TICK_CYCLES
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic SCLK,
   input wire logic SDI,
   input wire logic SERIAL_SELECT_N,
   output logic SDO,
   output logic SDO_OE,
   input wire logic SOFT_RESET,
   input wire logic RESTART,
   input wire logic HS_CLEARED_IN_RESTART,
   input wire logic PUMP_EN_WR,
   input wire logic PUMP_EN_WDATA,
   input wire logic THERMAL_SHUTDOWN_LEVEL2,
   input wire logic THERMAL_STREAK_CLR,
   output logic PUMP_OUTPUT_ENABLE,
   output logic [2:0] PIN_CFG,
   output logic HIGH_SIDE_OUTPUT,
   output logic TIMER_WAKE_EVENT,
   output logic UV_RELEASE_HYSTERESIS_SEL,
   output logic OVERTEMP_WAIT_EXTEND,
   output logic THERMAL_WAIT_ACTIVE,
   output logic RESET_DELAY_SEL,
   output logic LOCK1_ACTIVE
);
   logic sclk_q;
   logic sel_n_q;
   logic sclk_rise;
   logic sclk_fall;
   logic sel_rise;
   logic sel_fall;
   logic [15:0] shift_q;
   logic [4:0] bit_cnt_q;
   logic [7:0] sdo_sh_q;
   logic [7:0] rd_data;
   logic wr_go;
   logic [6:0] w_addr;
   logic [7:0] w_data;
   logic wr_tmr;
   logic wr_hw;
   logic wr_lock;
   logic wr_wake;
   logic wr_pin;
   logic [6:0] tmr_q;
   logic tmr_load_q;
   logic [2:0] opt_q;
   logic lk0_q;
   logic lk1_q;
   logic wake_q;
   logic [2:0] pin_q;
   logic pump_q;
   logic [15:0] tick_cnt_q;
   logic tick_q;
   logic tmr_hs;
   logic tmr_start;
   logic hs_q;
   logic wake_ev_q;

   function automatic logic wr_hit(input logic go, input logic [6:0] a,
                                   input logic [6:0] t);
      return go && (a == t);
   endfunction : wr_hit

   // inputs are synchronous, so one stage is enough for edge detection
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         sclk_q <= 1'b0;
         sel_n_q <= 1'b1;
      end else if (CE) begin
         sclk_q <= SCLK;
         sel_n_q <= SERIAL_SELECT_N;
      end
   end

   assign sclk_rise = SCLK & ~sclk_q & ~SERIAL_SELECT_N;
   assign sclk_fall = ~SCLK & sclk_q & ~SERIAL_SELECT_N;
   assign sel_rise = SERIAL_SELECT_N & ~sel_n_q;
   assign sel_fall = ~SERIAL_SELECT_N & sel_n_q;

   // lsb first: 7 address bits, write flag, 8 data bits
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         shift_q <= 16'h0000;
         bit_cnt_q <= 5'h00;
      end else if (CE) begin
         if (sel_fall) begin
            bit_cnt_q <= 5'h00;
         end else if (sclk_rise) begin
            shift_q <= {SDI, shift_q[15:1]};
            if (bit_cnt_q != FRAME_OVER) begin
               bit_cnt_q <= bit_cnt_q + 5'h01;
            end
         end
      end
   end

   always_comb begin
      unique case (shift_q[14:8])
         ADR_TIMER_CTRL: rd_data = {1'b0, tmr_q};
         ADR_HW_OPT: rd_data = {opt_q[2], 1'b0, opt_q[1], opt_q[0], lk0_q, 3'h0};
         ADR_HW_LOCK: rd_data = {7'h00, lk1_q};
         ADR_WAKE_CTRL: rd_data = {1'b0, wake_q, 6'h00};
         ADR_PIN_CFG: rd_data = {5'h00, pin_q};
         default: rd_data = 8'h00;
      endcase
   end

   // read data goes out on falling clock edges once the address is in
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         SDO <= 1'b0;
         sdo_sh_q <= 8'h00;
      end else if (CE) begin
         if (sel_fall) begin
            SDO <= 1'b0;
         end else if (sclk_fall) begin
            if (bit_cnt_q == ADDR_DONE) begin
               SDO <= rd_data[0];
               sdo_sh_q <= {1'b0, rd_data[7:1]};
            end else if (bit_cnt_q > ADDR_DONE) begin
               SDO <= sdo_sh_q[0];
               sdo_sh_q <= {1'b0, sdo_sh_q[7:1]};
            end
         end
      end
   end

   assign SDO_OE = ~SERIAL_SELECT_N;

   // writes commit only at select rise after exactly sixteen clocks
   assign wr_go = sel_rise && (bit_cnt_q == FRAME_LEN) && shift_q[WR_BIT];
   assign w_addr = shift_q[6:0];
   assign w_data = shift_q[15:8];
   assign wr_tmr = wr_hit(wr_go, w_addr, ADR_TIMER_CTRL);
   assign wr_hw = wr_hit(wr_go, w_addr, ADR_HW_OPT);
   assign wr_lock = wr_hit(wr_go, w_addr, ADR_HW_LOCK);
   assign wr_wake = wr_hit(wr_go, w_addr, ADR_WAKE_CTRL);
   assign wr_pin = wr_hit(wr_go, w_addr, ADR_PIN_CFG);

   // failure events have no path here, so the setting survives them
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         tmr_q <= TMR_CTRL_RST;
      end else if (CE) begin
         if (RESTART || SOFT_RESET) begin
            tmr_q <= TMR_CTRL_RST;
         end else if (HS_CLEARED_IN_RESTART && pin_q == PIN_CYCLIC_SENSE) begin
            tmr_q <= TMR_CTRL_RST;
         end else if (wr_tmr) begin
            tmr_q <= w_data[6:0];
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         tmr_load_q <= 1'b0;
      end else if (CE) begin
         tmr_load_q <= wr_tmr;
      end
   end

   // lockable options: a restart keeps them, soft reset only while unlocked
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         opt_q <= OPT_RST;
      end else if (CE) begin
         if (SOFT_RESET) begin
            if (!lk1_q) begin
               opt_q <= OPT_RST;
            end
         end else if (wr_hw && !lk1_q) begin
            opt_q <= {w_data[UVH_BIT], w_data[OTX_BIT], w_data[RDS_BIT]};
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         lk0_q <= 1'b0;
      end else if (CE) begin
         if (SOFT_RESET) begin
            lk0_q <= 1'b0;
         end else if (wr_hw) begin
            lk0_q <= w_data[LK0_BIT];
         end
      end
   end

   // only power-on clears it; it guards its own bit once set
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         lk1_q <= 1'b0;
      end else if (CE) begin
         if (wr_lock && w_data[LK1_BIT]) begin
            lk1_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         wake_q <= 1'b0;
      end else if (CE) begin
         if (SOFT_RESET) begin
            wake_q <= 1'b0;
         end else if (wr_wake) begin
            wake_q <= w_data[WAKE_EN_BIT];
         end
      end
   end

   // lock 0 uses its value before this cycle's soft reset
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pin_q <= PIN_CFG_RST;
      end else if (CE) begin
         if (SOFT_RESET) begin
            if (!lk0_q) begin
               pin_q <= PIN_CFG_RST;
            end
         end else if (wr_pin && !lk0_q) begin
            pin_q <= w_data[2:0];
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pump_q <= 1'b0;
      end else if (CE) begin
         if (SOFT_RESET) begin
            if (!lk0_q) begin
               pump_q <= 1'b0;
            end
         end else if (PUMP_EN_WR && !lk0_q) begin
            pump_q <= PUMP_EN_WDATA;
         end
      end
   end

   // shared time base; shortening TICK_LEN scales every timer count together
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         tick_cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (CE) begin
         if (tick_cnt_q >= 16'(TICK_LEN - 1)) begin
            tick_cnt_q <= 16'h0000;
            tick_q <= 1'b1;
         end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
            tick_q <= 1'b0;
         end
      end
   end

   cthw_cycle_timer u_timer (
      .clk(CORE_CLK),
      .rst(RST),
      .ce(CE),
      .tick(tick_q),
      .load(tmr_load_q),
      .on_code(tmr_q[6:TMR_ON_LSB]),
      .per_code(tmr_q[3:0]),
      .hs(tmr_hs),
      .period_start(tmr_start)
   );

   cthw_overtemp_wait u_overtemp (
      .clk(CORE_CLK),
      .rst(RST),
      .ce(CE),
      .tick(tick_q),
      .trip(THERMAL_SHUTDOWN_LEVEL2),
      .extend(opt_q[1]),
      .streak_clr(THERMAL_STREAK_CLR),
      .waiting(THERMAL_WAIT_ACTIVE)
   );

   // wake and sense read the same timer independently of each other
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         hs_q <= 1'b0;
         wake_ev_q <= 1'b0;
      end else if (CE) begin
         hs_q <= (pin_q == PIN_CYCLIC_SENSE) && tmr_hs;
         wake_ev_q <= tmr_start && wake_q;
      end
   end

   assign HIGH_SIDE_OUTPUT = hs_q;
   assign TIMER_WAKE_EVENT = wake_ev_q;
   assign PUMP_OUTPUT_ENABLE = pump_q;
   assign PIN_CFG = pin_q;
   assign UV_RELEASE_HYSTERESIS_SEL = opt_q[2];
   assign OVERTEMP_WAIT_EXTEND = opt_q[1];
   assign RESET_DELAY_SEL = opt_q[0];
   assign LOCK1_ACTIVE = lk1_q;
endmodule : cthw_ctrl_regs

// ---- testbench/cthw_ctrl_regs_monitor.sv ----
// port checker for the timer control and hardware option register block
module cthw_ctrl_regs_monitor
   import cthw_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic SERIAL_SELECT_N,
   input wire logic THERMAL_SHUTDOWN_LEVEL2,
   input wire logic [2:0] PIN_CFG,
   input wire logic HIGH_SIDE_OUTPUT,
   input wire logic TIMER_WAKE_EVENT,
   input wire logic UV_RELEASE_HYSTERESIS_SEL,
   input wire logic OVERTEMP_WAIT_EXTEND,
   input wire logic THERMAL_WAIT_ACTIVE,
   input wire logic RESET_DELAY_SEL,
   input wire logic LOCK1_ACTIVE
);
   logic [2:0] opts;
   assign opts = {UV_RELEASE_HYSTERESIS_SEL, OVERTEMP_WAIT_EXTEND, RESET_DELAY_SEL};
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);
   sequence s_locked;
      LOCK1_ACTIVE ##1 LOCK1_ACTIVE;
   endsequence
   // three cycles leave room for the registered gate of the output
   sequence s_pin_other;
      (PIN_CFG != PIN_CYCLIC_SENSE) [*3];
   endsequence
   wake_single_a: assert property (TIMER_WAKE_EVENT |=> !TIMER_WAKE_EVENT)
      else $error("timer wake event longer than one cycle");
   hs_gate_a: assert property (s_pin_other |-> !HIGH_SIDE_OUTPUT)
      else $error("high side output on without cyclic sense pin mode");
   lock1_hold_a: assert property (LOCK1_ACTIVE |=> LOCK1_ACTIVE)
      else $error("level one lock dropped before power up");
   lock1_select_a: assert property ($rose(LOCK1_ACTIVE) |-> SERIAL_SELECT_N)
      else $error("level one lock took effect inside a frame");
   lock1_freeze_a: assert property (s_locked |-> $stable(opts))
      else $error("lockable option changed while level one lock set");
   opt_commit_a: assert property ($changed(opts) |-> SERIAL_SELECT_N)
      else $error("option bits changed while frame open");
   pin_commit_a: assert property ($changed(PIN_CFG) |-> SERIAL_SELECT_N)
      else $error("pin configuration changed while frame open");
   thermal_wait_a: assert property (
      THERMAL_SHUTDOWN_LEVEL2 |-> ##[1:3] THERMAL_WAIT_ACTIVE)
      else $error("thermal release wait did not start");
endmodule : cthw_ctrl_regs_monitor

bind cthw_ctrl_regs cthw_ctrl_regs_monitor mon (
   .CORE_CLK(CORE_CLK), .RST(RST), .SERIAL_SELECT_N(SERIAL_SELECT_N),
   .THERMAL_SHUTDOWN_LEVEL2(THERMAL_SHUTDOWN_LEVEL2), .PIN_CFG(PIN_CFG),
   .HIGH_SIDE_OUTPUT(HIGH_SIDE_OUTPUT), .TIMER_WAKE_EVENT(TIMER_WAKE_EVENT),
   .UV_RELEASE_HYSTERESIS_SEL(UV_RELEASE_HYSTERESIS_SEL),
   .OVERTEMP_WAIT_EXTEND(OVERTEMP_WAIT_EXTEND), .THERMAL_WAIT_ACTIVE(THERMAL_WAIT_ACTIVE),
   .RESET_DELAY_SEL(RESET_DELAY_SEL), .LOCK1_ACTIVE(LOCK1_ACTIVE)
);

// ---- testbench/cthw_host_model.sv ----
// host side serial master: 16-bit frames, address then data, lsb first
module cthw_host_model (
   input wire logic clk,
   input wire logic sdo,
   output logic sclk,
   output logic sdi,
   output logic select_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'b0;
      sdi = 1'b0;
      select_n = 1'b1;
   end
   // slow stretches every half period by one cycle
   task automatic xfer(input logic [6:0] a, input logic wr, input logic [7:0] d,
      input int slow, output logic [7:0] q);
      logic [15:0] w;
      w = {d, wr, a};
      @(negedge clk);
      select_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         sclk = 1'b0;
         sdi = w[i];
         repeat (3 + slow) @(negedge clk);
         if (i > 7) q[i-8] = sdo;
         sclk = 1'b1;
         repeat (2 + slow) @(negedge clk);
      end
      @(negedge clk);
      sclk = 1'b0;
      repeat (2) @(negedge clk);
      select_n = 1'b1;
      // idle data line must not keep the last bit
      sdi = ~sdi;
      repeat (6) @(negedge clk);
   endtask : xfer
endmodule : cthw_host_model

// ---- testbench/cthw_ctrl_regs_test.sv ----
// self-checking bench for the timer control and hardware option registers
module cthw_ctrl_regs_test
   import cthw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TL = 2;
   localparam int ON_US[8] = '{0, 100, 300, 1000, 10000, 20000, 0, 0};
   localparam int PER_MS[3] = '{10, 20, 50};
   localparam int PC[6] = '{0, 0, 0, 0, 1, 2};
   localparam logic [6:0] ADRS[6] = '{ADR_WAKE_CTRL, ADR_TIMER_CTRL, ADR_HW_OPT,
      ADR_HW_LOCK, ADR_PIN_CFG, 7'h10};
   logic clk, rst, sclk, sdi, sel_n, sdo, pump_en, hs, wake_ev, uvh, otx, rds, tw_act, lock1;
   logic soft_rst, restart, hs_clr, pump_wr, pump_wd, thermal_shutdown_level2, streak_clr;
   logic [2:0] pin_cfg;
   logic sdo_oe;
   logic [7:0] q, d;
   int mismatches, n_tests, seed, h, p, w;

   cthw_ctrl_regs #(.TICK_LEN(TL)) dut (
      .CORE_CLK(clk), .RST(rst), .CE(1'b1), .SCLK(sclk), .SDI(sdi),
      .SERIAL_SELECT_N(sel_n), .SDO(sdo), .SDO_OE(sdo_oe), .SOFT_RESET(soft_rst),
      .RESTART(restart), .HS_CLEARED_IN_RESTART(hs_clr), .PUMP_EN_WR(pump_wr),
      .PUMP_EN_WDATA(pump_wd), .THERMAL_SHUTDOWN_LEVEL2(thermal_shutdown_level2),
      .THERMAL_STREAK_CLR(streak_clr), .PUMP_OUTPUT_ENABLE(pump_en), .PIN_CFG(pin_cfg),
      .HIGH_SIDE_OUTPUT(hs), .TIMER_WAKE_EVENT(wake_ev), .UV_RELEASE_HYSTERESIS_SEL(uvh),
      .OVERTEMP_WAIT_EXTEND(otx), .THERMAL_WAIT_ACTIVE(tw_act), .RESET_DELAY_SEL(rds),
      .LOCK1_ACTIVE(lock1)
   );
   cthw_host_model host (.clk(clk), .sdo(sdo), .sclk(sclk), .sdi(sdi), .select_n(sel_n));

   function automatic int on_cyc(input int c);
      return ON_US[c] / 10 * TL;
   endfunction : on_cyc
   function automatic int per_cyc(input int c);
      return PER_MS[c] * 100 * TL;
   endfunction : per_cyc
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // two ticks of phase either way are allowed
   task automatic chkn(input string n, input int e, input int g);
      n_tests++;
      if (g < e - 2 * TL || g > e + 2 * TL) begin
         mismatches++;
         $display("unexpected %s expected %0d seen %0d", n, e, g);
      end
   endtask : chkn
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      host.xfer(a, 1'b1, v, $random(seed) & 1, q);
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      host.xfer(a, 1'b0, 8'h00, $random(seed) & 1, q);
      chk($sformatf("reg_%h", a), e, q);
   endtask : rd
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      repeat (3) @(negedge clk);
   endtask : pulse
   task automatic wait_hs(input logic v, input int lim, inout int n, inout int k);
      int c;
      c = 0;
      while (hs !== v) begin
         @(negedge clk);
         n++;
         k += int'(wake_ev === 1'b1);
         c++;
         if (c > lim) begin
            mismatches++;
            $display("unexpected hs_wait expected %b seen %b", v, hs);
            final_report();
         end
      end
   endtask : wait_hs
   task automatic meas(input int lim);
      int x;
      x = 0;
      h = 0;
      wait_hs(1'b0, lim, x, x);
      wait_hs(1'b1, lim, x, x);
      w = 0;
      wait_hs(1'b0, lim, h, w);
      p = h;
      wait_hs(1'b1, lim, p, w);
   endtask : meas

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      $display("unexpected run_length expected end seen timeout");
      final_report();
   end
   initial begin
      seed = 32'h6bddd688;
      mismatches = 0;
      n_tests = 0;
      rst = 1'b1;
      {soft_rst, restart, hs_clr, pump_wr, pump_wd, thermal_shutdown_level2, streak_clr} = '0;
      // counting rising edges avoids the time-zero falling edge of the clock
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      foreach (ADRS[i]) rd(ADRS[i], 8'h00);
      wr(7'h10, 8'hff);
      rd(7'h10, 8'h00);
      chk("sdo_oe", 8'h00, sdo_oe);
      // on code 111 and period codes above 1100 are never written
      for (int c = 0; c < 13; c++) begin
         wr(ADR_TIMER_CTRL, {1'b1, 3'(c % 7), 4'(c)});
         rd(ADR_TIMER_CTRL, {1'b0, 3'(c % 7), 4'(c)});
      end
      repeat (8) begin
         d = 8'($random(seed));
         wr(ADR_HW_OPT, d);
         rd(ADR_HW_OPT, d & 8'hb8);
         chk("uv_hyst", d[7], uvh);
         chk("ot_extend", d[5], otx);
         chk("rst_delay", d[4], rds);
      end
      wr(ADR_HW_OPT, 8'h00);
      wr(ADR_PIN_CFG, {5'h00, PIN_CYCLIC_SENSE});
      wr(ADR_WAKE_CTRL, 8'h40);
      for (int c = 1; c < 6; c++) begin
         wr(ADR_TIMER_CTRL, {1'b0, 3'(c), 4'(PC[c])});
         meas(per_cyc(PC[c]) + 50);
         chkn("on_time", on_cyc(c), h);
         chkn("period", per_cyc(PC[c]), p);
         chk("wake_count", 8'h01, 8'(w));
      end
      // same timer, wake source off: periods go on without wake events
      wr(ADR_WAKE_CTRL, 8'h00);
      wr(ADR_TIMER_CTRL, 8'h10);
      meas(per_cyc(0) + 50);
      chk("wake_off", 8'h00, 8'(w));
      wr(ADR_TIMER_CTRL, 8'h60);
      repeat (3000) @(negedge clk);
      chk("hs_stop_high", 8'h01, hs);
      wr(ADR_TIMER_CTRL, 8'h00);
      repeat (3000) @(negedge clk);
      chk("hs_stop_low", 8'h00, hs);
      wr(ADR_TIMER_CTRL, 8'h12);
      repeat (300) @(negedge clk);
      chk("hs_off_phase", 8'h00, hs);
      wr(ADR_TIMER_CTRL, 8'h22);
      chk("hs_rewrite", 8'h01, hs);
      wr(ADR_HW_OPT, 8'hb0);
      pulse(thermal_shutdown_level2);
      chk("thermal_wait", 8'h01, tw_act);
      pulse(streak_clr);
      rd(ADR_TIMER_CTRL, 8'h22);
      pulse(restart);
      rd(ADR_TIMER_CTRL, 8'h00);
      rd(ADR_HW_OPT, 8'hb0);
      wr(ADR_TIMER_CTRL, 8'h22);
      pulse(hs_clr);
      rd(ADR_TIMER_CTRL, 8'h00);
      wr(ADR_HW_OPT, 8'h08);
      wr(ADR_PIN_CFG, 8'h05);
      rd(ADR_PIN_CFG, 8'h03);
      chk("pin_cfg", 8'h03, pin_cfg);
      pump_wd = 1'b1;
      pulse(pump_wr);
      chk("pump_locked", 8'h00, pump_en);
      wr(ADR_TIMER_CTRL, 8'h22);
      pulse(soft_rst);
      rd(ADR_PIN_CFG, 8'h03);
      rd(ADR_HW_OPT, 8'h00);
      rd(ADR_TIMER_CTRL, 8'h00);
      // the soft reset has cleared lock 0, so pin and pump can change again
      wr(ADR_PIN_CFG, 8'h05);
      rd(ADR_PIN_CFG, 8'h05);
      pulse(pump_wr);
      chk("pump_open", 8'h01, pump_en);
      wr(ADR_HW_OPT, 8'h90);
      wr(ADR_HW_LOCK, 8'h01);
      chk("lock1", 8'h01, lock1);
      wr(ADR_HW_OPT, 8'h28);
      rd(ADR_HW_OPT, 8'h98);
      wr(ADR_HW_LOCK, 8'h00);
      rd(ADR_HW_LOCK, 8'h01);
      pulse(soft_rst);
      rd(ADR_HW_OPT, 8'h90);
      rd(ADR_PIN_CFG, 8'h05);
      chk("pin_cfg", 8'h05, pin_cfg);
      final_report();
   end
endmodule : cthw_ctrl_regs_test
